// *** core/gsl_global_status.v ***
// Notes on behaviour
// - Step filter enable at bit 8 resets to 1; 0 disables step filtering.
// - Test bit 9 routes analog test to enable pin, pull-down off, driver enabled unless undervoltage.
// - Flag bit 0 reads 1 after any reset until software clears it.
// - Every register returns to its reset value on device reset.
// - Writing 1 clears that flag only; other flags stay unchanged.
// - Flag bit 1 sets when driver shut down by overtemperature or short; either fault sets it here, but drv_enable_r ignores both faults.
// - Driver fault clear succeeds only once all fault conditions are gone.
// - Flag bit 2 reads 1 during pump undervoltage; driver stays disabled then.
// - Undervoltage flag follows the live condition, never latched.
// - Eight-bit write counter increments after each successful write access.
// - Reads never change the write counter.
// - Write counter wraps from 255 to zero.
// - Reply delay bits 11:8, codes 0 and 1 give eight bit times.
`timescale 1ns/1ps
`default_nettype none
`include "gsl_regs.vh"

module gsl_global_status #(
    parameter FILT_CYC = 4
) (
    // Clock, reset, enable
    input wire ref_clk,
    input wire rst_b,
    input wire ce,
    // Register access from the serial framer
    input wire wr_stb,
    input wire wr_ok,
    input wire rd_stb,
    input wire [6:0] addr,
    input wire [31:0] wdata,
    output reg [31:0] rdata_r,
    output reg rvalid_r,
    // Pins and analog conditions
    input wire step_pin,
    input wire enable_low_pin,
    input wire overtemp_in,
    input wire short_in,
    input wire pump_uv_in,
    // Driver side
    output reg step_out_r,
    output reg drv_enable_r,
    output reg atest_route_r,
    output reg pin_pulldown_r,
    output reg [7:0] reply_delay_bits_r
);

////////////////////////////////////////////////////////////////////////////////
// Helpers

// Reply delay code to bit times
function [7:0] delay_bits;
    input [3:0] code;
    begin
        if (code < 4'h2) begin
            delay_bits = `GSL_DELAY_UNIT;
        end else begin
            delay_bits = {4'h0, code | 4'h1} * `GSL_DELAY_UNIT;
        end
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Synchronisers

// Two flops per asynchronous input; first stage read by second only
reg [4:0] sync1_r;
reg [4:0] sync2_r;
always @(posedge ref_clk) begin
    if (!rst_b) begin
        sync1_r <= 5'h00;
        sync2_r <= 5'h00;
    end else if (ce) begin
        sync1_r <= {pump_uv_in, short_in, overtemp_in, enable_low_pin, step_pin};
        sync2_r <= sync1_r;
    end
end

wire step_s = sync2_r[0];
wire en_low_s = sync2_r[1];
wire fault_s = sync2_r[2] | sync2_r[3];
wire uv_s = sync2_r[4];

////////////////////////////////////////////////////////////////////////////////
// Registers

reg filt_en_r;
reg test_mode_r;
reg flag_reset_r;
reg flag_drv_r;
reg [7:0] wcnt_r;
reg [3:0] reply_code_r;

wire wr_done = wr_stb & wr_ok;
wire wr_gconf = wr_done & (addr == `GSL_ADDR_GCONF);
wire wr_flags = wr_done & (addr == `GSL_ADDR_FLAGS);
wire wr_reply = wr_done & (addr == `GSL_ADDR_REPLY);

// Configuration and write counter
always @(posedge ref_clk) begin
    if (!rst_b) begin
        filt_en_r <= `GSL_FILT_RST;
        test_mode_r <= `GSL_TEST_RST;
        reply_code_r <= `GSL_REPLY_RST;
        wcnt_r <= `GSL_WCNT_RST;
    end else if (ce) begin
        if (wr_gconf) begin
            filt_en_r <= wdata[`GSL_GCONF_FILT_BIT];
            test_mode_r <= wdata[`GSL_GCONF_TEST_BIT];
        end
        if (wr_reply) begin
            reply_code_r <= wdata[`GSL_REPLY_MSB:`GSL_REPLY_LSB];
        end
        if (wr_done) begin
            wcnt_r <= wcnt_r + 8'h01;
        end
    end
end

// Sticky flags; a setting event wins over a clear
always @(posedge ref_clk) begin
    if (!rst_b) begin
        flag_reset_r <= 1'b1;
        flag_drv_r <= 1'b0;
    end else if (ce) begin
        // clear only bits written with one
        if (wr_flags && wdata[`GSL_FLAG_RESET_BIT]) begin
            flag_reset_r <= 1'b0;
        end
        if (fault_s) begin
            flag_drv_r <= 1'b1;
        end else if (wr_flags && wdata[`GSL_FLAG_DRVERR_BIT]) begin
            flag_drv_r <= 1'b0;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Read port

// Write-only reply config and unmapped addresses read zero
reg [31:0] rd_mux;
always @* begin
    rd_mux = 32'h0000_0000;
    case (addr)
        `GSL_ADDR_GCONF: begin
            rd_mux[`GSL_GCONF_FILT_BIT] = filt_en_r;
            rd_mux[`GSL_GCONF_TEST_BIT] = test_mode_r;
        end
        `GSL_ADDR_FLAGS: begin
            rd_mux[`GSL_FLAG_RESET_BIT] = flag_reset_r;
            rd_mux[`GSL_FLAG_DRVERR_BIT] = flag_drv_r;
            rd_mux[`GSL_FLAG_UV_BIT] = uv_s;
        end
        `GSL_ADDR_WCNT: begin
            rd_mux[7:0] = wcnt_r;
        end
        default: begin
            rd_mux = 32'h0000_0000;
        end
    endcase
end

// Read answer one cycle after the strobe
always @(posedge ref_clk) begin
    if (!rst_b) begin
        rdata_r <= 32'h0000_0000;
        rvalid_r <= 1'b0;
    end else if (ce) begin
        rvalid_r <= rd_stb;
        if (rd_stb) begin
            rdata_r <= rd_mux;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Step filter

// Filter adds FILT_CYC-1 cycles of latency but rejects short glitches
reg [7:0] filt_cnt_r;
always @(posedge ref_clk) begin
    if (!rst_b) begin
        filt_cnt_r <= 8'h00;
        step_out_r <= 1'b0;
    end else if (ce) begin
        if (!filt_en_r) begin
            step_out_r <= step_s;
            filt_cnt_r <= 8'h00;
        end else if (step_s == step_out_r) begin
            filt_cnt_r <= 8'h00;
        end else if (filt_cnt_r >= FILT_CYC[7:0] - 8'h01) begin
            step_out_r <= step_s;
            filt_cnt_r <= 8'h00;
        end else begin
            filt_cnt_r <= filt_cnt_r + 8'h01;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Driver enable, test routing, reply delay

always @(posedge ref_clk) begin
    if (!rst_b) begin
        drv_enable_r <= 1'b0;
        atest_route_r <= 1'b0;
        pin_pulldown_r <= 1'b1;
        reply_delay_bits_r <= `GSL_DELAY_UNIT;
    end else if (ce) begin
        // test mode treats pin as enabled
        drv_enable_r <= (test_mode_r | ~en_low_s) & ~uv_s;
        atest_route_r <= test_mode_r;
        pin_pulldown_r <= ~test_mode_r;
        // codes 0 and 1 give 8
        reply_delay_bits_r <= delay_bits(reply_code_r);
    end
end

endmodule // gsl_global_status
`default_nettype wire

// *** shared/gsl_regs.vh ***
`ifndef GSL_REGS_VH
`define GSL_REGS_VH

// Register addresses
`define GSL_ADDR_GCONF 7'h00
`define GSL_ADDR_FLAGS 7'h01
`define GSL_ADDR_WCNT 7'h02
`define GSL_ADDR_REPLY 7'h03

// General configuration field positions
`define GSL_GCONF_FILT_BIT 8
`define GSL_GCONF_TEST_BIT 9

// Global flag positions
`define GSL_FLAG_RESET_BIT 0
`define GSL_FLAG_DRVERR_BIT 1
`define GSL_FLAG_UV_BIT 2

// Reply delay field position
`define GSL_REPLY_LSB 8
`define GSL_REPLY_MSB 11

// Reset values
`define GSL_FILT_RST 1'b1
`define GSL_TEST_RST 1'b0
`define GSL_REPLY_RST 4'h0
`define GSL_WCNT_RST 8'h00

// Bit times per reply delay unit
`define GSL_DELAY_UNIT 8'h08

`endif

// *** verif/gsl_host.sv ***
`timescale 1ns/1ps
`default_nettype none
// Host model: one-cycle strobes, data scrambled once released
module gsl_host (
    // Clock
    input wire logic ref_clk,
    // Requests
    output logic wr_stb,
    output logic wr_ok,
    output logic rd_stb,
    output logic [6:0] addr,
    output logic [31:0] wdata
);
    initial {wr_stb, wr_ok, rd_stb, addr, wdata} = 0;
    task automatic xfer(logic w, ok, logic [6:0] a, logic [31:0] d);
        @(posedge ref_clk);
        {wr_stb, wr_ok, rd_stb, addr, wdata} <= {w, ok, !w, a, d};
        @(posedge ref_clk);
        {wr_stb, rd_stb, wdata} <= {2'b00, ~d};
    endtask
endmodule // gsl_host
`default_nettype wire

// *** verif/gsl_global_status_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
// Watches answers, reply delay and driver outputs
module gsl_gs_sva (
    // Clock, reset, register port
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic wr_stb,
    input wire logic wr_ok,
    input wire logic rd_stb,
    input wire logic rvalid_r,
    input wire logic [6:0] addr,
    input wire logic [31:0] wdata,
    input wire logic [31:0] rdata_r,
    // Pins and outputs
    input wire logic pump_uv_in,
    input wire logic drv_enable_r,
    input wire logic atest_route_r,
    input wire logic pin_pulldown_r,
    input wire logic [7:0] reply_delay_bits_r
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    ////////////////////////////////
    read_answer_a: assert property (rd_stb |=> rvalid_r)
        else $error("no answer");
    no_answer_a: assert property (!rd_stb |=> !rvalid_r)
        else $error("stray answer");
    wo_read_a: assert property (rd_stb && addr == 7'h03 |=> rdata_r == 0)
        else $error("config readable");
    // Two sync flops plus a register: four samples settle it
    uv_off_a: assert property (pump_uv_in [*4] |-> !drv_enable_r)
        else $error("driver on");
    test_pull_a: assert property (atest_route_r |-> !pin_pulldown_r)
        else $error("pull-down on");
    delay_odd_a: assert property (reply_delay_bits_r[3] && !reply_delay_bits_r[2:0])
        else $error("bad delay");
    delay_set_a: assert property (wr_stb && wr_ok && addr == 7'h03
        |-> ##2 reply_delay_bits_r == {1'b0, $past(wdata[11:9], 2), 4'h8}) else $error("delay");
    reset_vals_a: assert property (disable iff (1'b0) !rst_b
        |=> !rvalid_r && pin_pulldown_r && reply_delay_bits_r == 8'h08) else $error("reset");
    // Main scenarios reached
    cover property (rd_stb && addr == 7'h02);
    cover property (wr_stb && wr_ok && addr == 7'h03);
    cover property (atest_route_r);
endmodule // gsl_gs_sva
`default_nettype wire

// *** verif/gsl_global_status_test.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin err_total++; \
    $display("MISMATCH %0t got %h", $time, a); end end
module gsl_global_status_test;
    logic ref_clk = 0, rst_b = 0, ce = 1, step_pin = 0, enable_low_pin = 0, overtemp_in = 0;
    logic short_in = 0, pump_uv_in = 0, wr_stb, wr_ok, rd_stb, rvalid_r, step_out_r;
    logic drv_enable_r, atest_route_r, pin_pulldown_r, seen;
    logic [6:0] addr;
    logic [31:0] wdata, rdata_r, exp_q[$];
    logic [7:0] reply_delay_bits_r, wcnt = 0;
    int err_total = 0, cmp_count = 0;
    integer seed = 16;
    // 40 MHz clock
    always #12.5 ref_clk = ~ref_clk;
    gsl_host u_host (.*);
    gsl_global_status #(.FILT_CYC(4)) u_dut (.*);
    // Each answer is paired with the oldest note
    always @(posedge ref_clk) if (rvalid_r === 1'b1) `CHK(rdata_r, exp_q.pop_front())
    ////////////////////////////////
    task automatic tick(int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic wr(logic [6:0] a, logic [31:0] d, logic ok = 1);
        u_host.xfer(1, ok, a, d);
        wcnt += ok;
    endtask
    task automatic rd(logic [6:0] a, logic [31:0] e);
        exp_q.push_back(e);
        u_host.xfer(0, 0, a, 0);
    endtask
    // Two-cycle step pulse, shorter than the filter span
    task automatic pulse(logic e);
        seen = 0;
        step_pin <= 1;
        tick(2);
        step_pin <= 0;
        repeat (8) @(posedge ref_clk) seen |= step_out_r;
        `CHK(seen, e)
    endtask
    task automatic final_report;
        $display("compares %0d errors %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Main sequence
    initial begin
        tick(4);
        rst_b <= 1;
        `CHK(reply_delay_bits_r, 8'h08)
        rd(7'h01, 1);
        wr(7'h02, 0, 0);
        rd(7'h02, 0);
        wr(7'h01, 6);
        rd(7'h01, 1);
        wr(7'h01, 1);
        rd(7'h01, 0);
        overtemp_in <= 1;
        tick(4);
        wr(7'h01, 2);
        rd(7'h01, 2);
        {overtemp_in, short_in} <= 2'b01;
        tick(4);
        short_in <= 0;
        tick(4);
        rd(7'h01, 2);
        wr(7'h01, 2);
        rd(7'h01, 0);
        pump_uv_in <= 1;
        tick(4);
        rd(7'h01, 4);
        pump_uv_in <= 0;
        tick(4);
        rd(7'h01, 0);
        for (int c = 0; c < 16; c++) begin
            wr(7'h03, c << 8);
            tick(2);
            `CHK(reply_delay_bits_r, c < 2 ? 8'h08 : 8'(c | 1) * 8'h08)
        end
        rd(7'h03, 0);
        repeat (260) wr(7'h05, $random(seed));
        // A write while the clock enable is low must leave no trace
        ce <= 0;
        u_host.xfer(1, 1, 7'h05, 0);
        ce <= 1;
        rd(7'h02, wcnt);
        pulse(0);
        wr(7'h00, 0);
        pulse(1);
        enable_low_pin <= 1;
        tick(4);
        `CHK(drv_enable_r, 1'b0)
        wr(7'h00, 32'h0000_0200);
        tick(4);
        `CHK({atest_route_r, pin_pulldown_r, drv_enable_r}, 3'b101)
        rd(7'h00, 32'h0000_0200);
        // Mid-run reset brings every register back
        rst_b <= 0;
        tick(2);
        rst_b <= 1;
        wcnt = 0;
        rd(7'h02, 0);
        rd(7'h01, 1);
        rd(7'h00, 32'h0000_0100);
        tick(2);
        `CHK({atest_route_r, pin_pulldown_r}, 2'b01)
        final_report;
    end
    // Cut a hang; the run needs about 690 cycles
    initial begin
        #100_000;
        err_total++;
        final_report;
    end
endmodule // gsl_global_status_test
bind gsl_global_status gsl_gs_sva u_sva (.*);
`default_nettype wire
